// ===== link_frame_statistics_counters.sv
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - 8-bit count of discarded UART response frames, readable at its own address.
// - Discards caused by a frame integrity error do not advance that count.
// - Reading UART stats reg3 latches all UART statistics and clears UART counters.
// - Reading low-side stats reg3 latches low-side statistics and clears its counters.
// - 16-bit low-side good command count; upper byte first address, lower next.
// - Low-side good command count stops at its maximum, never wraps.
module link_frame_statistics_counters
   import link_stats_pkg::*;
#(
   parameter int DROP_W = 8,
   parameter int GOOD_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [DATA_W-1:0] writedata,
   input  wire logic [3:0]        byteenable,
   output var  logic [DATA_W-1:0] readdata,
   output var  logic              waitrequest,
   output var  logic [1:0]        response,
   input  wire logic              uart_response_dropped,
   input  wire logic              frame_integrity_error,
   input  wire logic              uart_good_cmd,
   input  wire logic              lowside_good_cmd
);

   // ==========================================================
   // Parameter checks
   generate
      if (GOOD_W != 2 * BYTE_W) begin : g_bad_good
         $error("GOOD_W must span exactly two register bytes");
      end
      if ((DROP_W < 1) || (DROP_W > BYTE_W)) begin : g_bad_drop
         $error("DROP_W must fit one register byte");
      end
   endgenerate

   // ==========================================================
   // State: latched statistics and counting control
   typedef struct packed {
      logic [DROP_W-1:0] uart_drop_snap;
      logic [GOOD_W-1:0] uart_good_snap;
      logic [GOOD_W-1:0] low_good_snap;
      logic [CTRL_W-1:0] ctrl;
   } stat_state_t;

   stat_state_t       st_ff;
   stat_state_t       nxt_st;

   logic [IDX_W-1:0]  idx;
   logic              take;
   logic              clr_uart;
   logic              clr_low;
   logic              drop_inc;
   logic              uart_good_inc;
   logic              low_good_inc;
   logic [DROP_W-1:0] uart_drop_live;
   logic [GOOD_W-1:0] uart_good_live;
   logic [GOOD_W-1:0] low_good_live;
   logic [8:0]        rd_sel;
   logic [DATA_W-1:0] rd_word;

   assign idx = address[ADDR_W-1:2];

   // ==========================================================
   // Read decode: returns {hit, byte} for a word index
   function automatic logic [8:0] read_byte(input logic [IDX_W-1:0] i,
                                            input stat_state_t       s);
      logic [8:0] r;
      r = '0;
      if (i == IDX_UART_DROP) begin
         r = {1'b1, BYTE_W'(s.uart_drop_snap)};
      end else if (i == IDX_UART_GOOD_HI) begin
         r = {1'b1, s.uart_good_snap[GOOD_W-1:BYTE_W]};
      end else if (i == IDX_UART_GOOD_LO) begin
         r = {1'b1, s.uart_good_snap[BYTE_W-1:0]};
      end else if (i == IDX_LOW_GOOD_HI) begin
         r = {1'b1, s.low_good_snap[GOOD_W-1:BYTE_W]};
      end else if (i == IDX_LOW_GOOD_LO) begin
         r = {1'b1, s.low_good_snap[BYTE_W-1:0]};
      end else if ((i == IDX_UART_REG3) || (i == IDX_LOW_REG3)) begin
         r = {1'b1, STAT_RST};
      end else if (i == IDX_COUNT_CTRL) begin
         r = {1'b1, {(BYTE_W-CTRL_W){1'b0}}, s.ctrl};
      end
      return r;
   endfunction

   assign rd_sel  = read_byte(idx, st_ff);
   assign rd_word = {{(DATA_W-BYTE_W){1'b0}}, rd_sel[7:0]};

   // ==========================================================
   // Bus slave
   avmm_slave_port u_bus (
      .clk         (clk),
      .rst_b       (rst_b),
      .read        (read),
      .write       (write),
      .rd_word     (rd_word),
      .hit         (rd_sel[8]),
      .take        (take),
      .readdata    (readdata),
      .waitrequest (waitrequest),
      .response    (response)
   );

   // ==========================================================
   // Interval boundaries: one pulse per accepted read of a reg3
   assign clr_uart = take && read && (idx == IDX_UART_REG3);
   assign clr_low  = take && read && (idx == IDX_LOW_REG3);

   // Counting events, gated by the enables
   assign drop_inc      = uart_response_dropped && !frame_integrity_error
                          && st_ff.ctrl[CTRL_UART_EN_BIT];
   assign uart_good_inc = uart_good_cmd && st_ff.ctrl[CTRL_UART_EN_BIT];
   assign low_good_inc  = lowside_good_cmd && st_ff.ctrl[CTRL_LOW_EN_BIT];

   // ==========================================================
   // Live counters
   sat_counter #(.WIDTH(DROP_W)) u_uart_drop (
      .clk   (clk),
      .rst_b (rst_b),
      .clear (clr_uart),
      .inc   (drop_inc),
      .count (uart_drop_live)
   );

   sat_counter #(.WIDTH(GOOD_W)) u_uart_good (
      .clk   (clk),
      .rst_b (rst_b),
      .clear (clr_uart),
      .inc   (uart_good_inc),
      .count (uart_good_live)
   );

   sat_counter #(.WIDTH(GOOD_W)) u_low_good (
      .clk   (clk),
      .rst_b (rst_b),
      .clear (clr_low),
      .inc   (low_good_inc),
      .count (low_good_live)
   );

   // ==========================================================
   // Snapshot latching and control writes
   always_comb begin
      nxt_st = st_ff;
      if (clr_uart) begin
         nxt_st.uart_drop_snap = uart_drop_live;
         nxt_st.uart_good_snap = uart_good_live;
      end
      if (clr_low) begin
         nxt_st.low_good_snap = low_good_live;
      end
      if (take && write && (idx == IDX_COUNT_CTRL) && byteenable[0]) begin
         nxt_st.ctrl = writedata[CTRL_W-1:0];
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff.uart_drop_snap <= '0;
         st_ff.uart_good_snap <= '0;
         st_ff.low_good_snap  <= '0;
         st_ff.ctrl           <= CTRL_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Assertions
   a_drop_counts_clean: assert property (@(posedge clk) disable iff (!rst_b)
      (drop_inc && !clr_uart && (uart_drop_live != {DROP_W{1'b1}}))
      |=> (uart_drop_live == $past(uart_drop_live) + DROP_W'(1)))
      else $error("dropped frame count did not advance");

   a_drop_frame_integrity_error_blocked: assert property (@(posedge clk) disable iff (!rst_b)
      (uart_response_dropped && frame_integrity_error && !uart_good_cmd
       && !clr_uart) |=> (uart_drop_live == $past(uart_drop_live)))
      else $error("integrity error advanced dropped count");

   a_uart_latch_clear: assert property (@(posedge clk) disable iff (!rst_b)
      clr_uart |=> ((st_ff.uart_good_snap == $past(uart_good_live))
                    && (st_ff.uart_drop_snap == $past(uart_drop_live))
                    && (uart_good_live <= GOOD_W'(1))))
      else $error("UART statistics not latched and cleared");

   a_low_latch_clear: assert property (@(posedge clk) disable iff (!rst_b)
      clr_low |=> ((st_ff.low_good_snap == $past(low_good_live))
                   && (low_good_live <= GOOD_W'(1))))
      else $error("low-side statistics not latched and cleared");

   a_low_bytes_split: assert property (@(posedge clk) disable iff (!rst_b)
      (take && read && (idx == IDX_LOW_GOOD_HI))
      |=> (!waitrequest && (readdata[7:0] == $past(st_ff.low_good_snap[15:8]))))
      else $error("low-side upper byte misplaced");

   a_low_sat_hold: assert property (@(posedge clk) disable iff (!rst_b)
      ((low_good_live == {GOOD_W{1'b1}}) && !clr_low)
      |=> (low_good_live == {GOOD_W{1'b1}}))
      else $error("low-side good count wrapped");

   a_uart_sat_hold: assert property (@(posedge clk) disable iff (!rst_b)
      ((uart_good_live == {GOOD_W{1'b1}}) && !clr_uart)
      |=> (uart_good_live == {GOOD_W{1'b1}}))
      else $error("UART good count wrapped");

   a_bus_one_wait: assert property (@(posedge clk) disable iff (!rst_b)
      ((read || write) && waitrequest) |=> !waitrequest)
      else $error("bus answer took more than one wait cycle");

   // Control register and counting enables
   a_ctrl_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
      (take && write && (idx == IDX_COUNT_CTRL) && byteenable[0])
      |=> (st_ff.ctrl == $past(writedata[CTRL_W-1:0])))
      else $error("control write did not land");

   a_ctrl_byte_gate: assert property (@(posedge clk) disable iff (!rst_b)
      (take && write && (idx == IDX_COUNT_CTRL) && !byteenable[0])
      |=> $stable(st_ff.ctrl))
      else $error("control write without its byte lane landed");

   a_ctrl_gates_uart: assert property (@(posedge clk) disable iff (!rst_b)
      (!st_ff.ctrl[CTRL_UART_EN_BIT] && !clr_uart)
      |=> ((uart_good_live == $past(uart_good_live))
           && (uart_drop_live == $past(uart_drop_live))))
      else $error("UART counts moved while paused");

   a_ctrl_gates_low: assert property (@(posedge clk) disable iff (!rst_b)
      (!st_ff.ctrl[CTRL_LOW_EN_BIT] && !clr_low)
      |=> (low_good_live == $past(low_good_live)))
      else $error("low-side count moved while paused");

   // Snapshots change only at an interval boundary
   a_uart_snap_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !clr_uart
      |=> ($stable(st_ff.uart_good_snap) && $stable(st_ff.uart_drop_snap)))
      else $error("UART snapshot changed outside a boundary");

   a_low_snap_hold: assert property (@(posedge clk) disable iff (!rst_b)
      !clr_low
      |=> $stable(st_ff.low_good_snap))
      else $error("low-side snapshot changed outside a boundary");

   // Counting steps and saturation
   a_uart_good_step: assert property (@(posedge clk) disable iff (!rst_b)
      (uart_good_inc && !clr_uart && (uart_good_live != {GOOD_W{1'b1}}))
      |=> (uart_good_live == $past(uart_good_live) + GOOD_W'(1)))
      else $error("UART good count did not advance");

   a_low_good_step: assert property (@(posedge clk) disable iff (!rst_b)
      (low_good_inc && !clr_low && (low_good_live != {GOOD_W{1'b1}}))
      |=> (low_good_live == $past(low_good_live) + GOOD_W'(1)))
      else $error("low-side good count did not advance");

   a_drop_sat_hold: assert property (@(posedge clk) disable iff (!rst_b)
      ((uart_drop_live == {DROP_W{1'b1}}) && !clr_uart)
      |=> (uart_drop_live == {DROP_W{1'b1}}))
      else $error("dropped frame count wrapped");

   // Read data placement and answer codes
   a_drop_reads_snap: assert property (@(posedge clk) disable iff (!rst_b)
      (take && read && (idx == IDX_UART_DROP))
      |=> (readdata == DATA_W'($past(st_ff.uart_drop_snap))))
      else $error("dropped frame count misplaced");

   a_uart_hi_byte: assert property (@(posedge clk) disable iff (!rst_b)
      (take && read && (idx == IDX_UART_GOOD_HI))
      |=> (readdata == DATA_W'($past(st_ff.uart_good_snap[15:8]))))
      else $error("UART upper byte misplaced");

   a_low_lo_byte: assert property (@(posedge clk) disable iff (!rst_b)
      (take && read && (idx == IDX_LOW_GOOD_LO))
      |=> (readdata == DATA_W'($past(st_ff.low_good_snap[7:0]))))
      else $error("low-side lower byte misplaced");

   a_reg3_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (take && read && ((idx == IDX_UART_REG3) || (idx == IDX_LOW_REG3)))
      |=> ((readdata == '0) && (response == RESP_OKAY)))
      else $error("boundary register read returned data");

   a_unmapped_decode: assert property (@(posedge clk) disable iff (!rst_b)
      (take && !rd_sel[8]) |=> (response == RESP_DECODE_ERR))
      else $error("unmapped access not answered with decode error");

   c_uart_snapshot: cover property (@(posedge clk) disable iff (!rst_b)
      clr_uart && (uart_good_live != '0));
   c_low_saturate: cover property (@(posedge clk) disable iff (!rst_b)
      low_good_live == {GOOD_W{1'b1}});
   c_drop_frame_integrity_error: cover property (@(posedge clk) disable iff (!rst_b)
      uart_response_dropped && frame_integrity_error);
   c_ctrl_paused: cover property (@(posedge clk) disable iff (!rst_b)
      take && write && (idx == IDX_COUNT_CTRL) && (writedata[CTRL_W-1:0] != CTRL_RST));
   c_drop_saturated: cover property (@(posedge clk) disable iff (!rst_b)
      clr_uart && (uart_drop_live == {DROP_W{1'b1}}));

endmodule
`default_nettype wire

// ===== link_stats_pkg.sv
`default_nettype none
// ==========================================================
// Register map and constants of the frame statistics block
package link_stats_pkg;

   // Bus geometry: byte address, word index = address[11:2]
   localparam int          ADDR_W   = 12;
   localparam int          IDX_W    = 10;
   localparam int          DATA_W   = 32;
   localparam int          BYTE_W   = 8;

   // Register indices; byte address is four times the index
   localparam logic [9:0]  IDX_UART_DROP     = 10'h26A;
   localparam logic [9:0]  IDX_UART_GOOD_HI  = 10'h26B;
   localparam logic [9:0]  IDX_UART_GOOD_LO  = 10'h26C;
   localparam logic [9:0]  IDX_LOW_GOOD_HI   = 10'h26D;
   localparam logic [9:0]  IDX_LOW_GOOD_LO   = 10'h26E;
   localparam logic [9:0]  IDX_UART_REG3     = 10'h280;
   localparam logic [9:0]  IDX_LOW_REG3      = 10'h281;
   localparam logic [9:0]  IDX_COUNT_CTRL    = 10'h282;

   // Control register fields
   localparam int          CTRL_UART_EN_BIT  = 0;
   localparam int          CTRL_LOW_EN_BIT   = 1;
   localparam int          CTRL_W            = 2;

   // Reset values
   localparam logic [7:0]  STAT_RST          = 8'h00;
   localparam logic [1:0]  CTRL_RST          = 2'h3;

   // Avalon response codes
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_DECODE_ERR   = 2'h3;

endpackage
`default_nettype wire

// ===== sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Saturating event counter with synchronous clear
module sat_counter #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             clear,
   input  wire logic             inc,
   output var  logic [WIDTH-1:0] count
);

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } cnt_state_t;

   cnt_state_t st_ff;
   cnt_state_t nxt_st;

   // Width check
   generate
      if (WIDTH < 1) begin : g_bad_width
         $error("sat_counter needs WIDTH of at least one");
      end
   endgenerate

   // Clear restarts the interval; an event in the clear cycle is kept
   always_comb begin
      nxt_st = st_ff;
      if (clear) begin
         nxt_st.cnt = inc ? WIDTH'(1) : '0;
      end else if (inc && (st_ff.cnt != {WIDTH{1'b1}})) begin
         nxt_st.cnt = st_ff.cnt + WIDTH'(1);
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign count = st_ff.cnt;

endmodule
`default_nettype wire

// ===== avmm_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Avalon-MM slave: one wait state, registered answer
module avmm_slave_port
   import link_stats_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [DATA_W-1:0] rd_word,
   input  wire logic              hit,
   output var  logic              take,
   output var  logic [DATA_W-1:0] readdata,
   output var  logic              waitrequest,
   output var  logic [1:0]        response
);

   typedef struct packed {
      logic              ack;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        resp;
   } bus_state_t;

   bus_state_t st_ff;
   bus_state_t nxt_st;

   // Request is taken in its first cycle, released the cycle after
   assign take        = (read || write) && !st_ff.ack;
   assign waitrequest = take;

   // Answer is captured at the taking edge
   always_comb begin
      nxt_st     = st_ff;
      nxt_st.ack = take;
      if (take) begin
         nxt_st.resp = hit ? RESP_OKAY : RESP_DECODE_ERR;
         if (read) begin
            nxt_st.rdata = hit ? rd_word : '0;
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign readdata = st_ff.rdata;
   assign response = st_ff.resp;

endmodule
`default_nettype wire

// ===== frame_event_src.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Frame receive side: emits one burst of per-cycle event pulses
module frame_event_src (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        start,
   input  wire logic [3:0]  mask,
   input  wire logic [16:0] len,
   output var  logic        busy,
   output var  logic        drop_ev,
   output var  logic        frame_integrity_error_ev,
   output var  logic        ugood_ev,
   output var  logic        lgood_ev
);
   logic [16:0] left_ff;
   logic [3:0]  mask_ff;

   // Burst length counter, loaded on start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         left_ff <= 17'h0;
         mask_ff <= 4'h0;
      end else if (start && left_ff == 17'h0) begin
         left_ff <= len;
         mask_ff <= mask;
      end else if (left_ff != 17'h0) begin
         left_ff <= left_ff - 17'h1;
      end
   end

   // Event lines rest low outside a burst
   always_comb begin
      busy     = (left_ff != 17'h0);
      drop_ev  = busy & mask_ff[0];
      frame_integrity_error_ev  = busy & mask_ff[1];
      ugood_ev = busy & mask_ff[2];
      lgood_ev = busy & mask_ff[3];
   end
endmodule
`default_nettype wire

// ===== link_frame_statistics_counters_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench with an integer model of the counters
module link_frame_statistics_counters_tb_top
   import link_stats_pkg::*;
   ;

   logic              clk;
   logic              rst_b;
   logic [ADDR_W-1:0] address;
   logic              read;
   logic              write;
   logic [DATA_W-1:0] writedata;
   logic [3:0]        byteenable;
   logic [DATA_W-1:0] readdata;
   logic              waitrequest;
   logic [1:0]        response;
   logic              start;
   logic [3:0]        mask;
   logic [16:0]       len;
   logic              busy;
   logic              drop_ev;
   logic              frame_integrity_error_ev;
   logic              ugood_ev;
   logic              lgood_ev;
   int                errors;
   int                checked;
   int                ld, lu, ll, sd, su, sl;
   logic [31:0]       d;
   logic [1:0]        r;
   logic [1:0]        en;
   logic [3:0]        tbl [3] = '{4'h3, 4'h1, 4'hC};

   link_frame_statistics_counters u_dut (
      .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .response(response),
      .uart_response_dropped(drop_ev), .frame_integrity_error(frame_integrity_error_ev),
      .uart_good_cmd(ugood_ev), .lowside_good_cmd(lgood_ev)
   );

   frame_event_src u_src (
      .clk(clk), .rst_b(rst_b), .start(start), .mask(mask), .len(len), .busy(busy),
      .drop_ev(drop_ev), .frame_integrity_error_ev(frame_integrity_error_ev), .ugood_ev(ugood_ev), .lgood_ev(lgood_ev)
   );

   // Clock generation
   always #5 clk = ~clk;

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      address   <= {idx, 2'b00};
      read      <= ~wr;
      write     <= wr;
      writedata <= wd;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      d = readdata;
      r = response;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask

   // Read one register and compare data and response
   task automatic rd_chk(input logic [9:0] idx, input int exp);
      bus(1'b0, idx, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      chk(d, exp);
   endtask

   // All visible statistics against the model snapshots
   task automatic all_chk();
      rd_chk(IDX_UART_DROP, sd);
      rd_chk(IDX_UART_GOOD_HI, su >> 8);
      rd_chk(IDX_UART_GOOD_LO, su & 8'hFF);
      rd_chk(IDX_LOW_GOOD_HI, sl >> 8);
      rd_chk(IDX_LOW_GOOD_LO, sl & 8'hFF);
   endtask

   function automatic int sat(input int v, input int m);
      return (v > m) ? m : v;
   endfunction

   // One burst from the frame side, mirrored in the model
   task automatic burst(input logic [3:0] m, input int n);
      mask  <= m;
      len   <= n[16:0];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
      wait (busy === 1'b0);
      @(posedge clk);
      if (m[0] && !m[1] && en[CTRL_UART_EN_BIT]) ld = sat(ld + n, 255);
      if (m[2] && en[CTRL_UART_EN_BIT]) lu = sat(lu + n, 65535);
      if (m[3] && en[CTRL_LOW_EN_BIT]) ll = sat(ll + n, 65535);
   endtask

   // Reading reg3 latches and restarts that port's counters
   task automatic snap(input int sel);
      if (sel != 1) begin
         rd_chk(IDX_UART_REG3, 0);
         sd = ld; su = lu; ld = 0; lu = 0;
      end
      if (sel != 0) begin
         rd_chk(IDX_LOW_REG3, 0);
         sl = ll; ll = 0;
      end
   endtask

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog beyond the longest saturation burst, inside the cycle budget
   initial begin
      #900000;
      errors++;
      print_verdict();
   end

   // Main sequence
   initial begin
      clk = 1'b0; rst_b = 1'b0; address = '0; read = 1'b0; write = 1'b0;
      writedata = '0; byteenable = 4'hF; start = 1'b0; mask = 4'h0; len = '0;
      errors = 0; checked = 0;
      ld = 0; lu = 0; ll = 0; sd = 0; su = 0; sl = 0;
      en = CTRL_RST;
      void'($urandom(89363));
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // Reset values of all statistics
      all_chk();
      // Unmapped index answers with a decode error
      bus(1'b0, 10'h300, 32'h0);
      chk({30'h0, r}, {30'h0, RESP_DECODE_ERR});
      chk(d, 32'h0);
      // Write to a read-only count is ignored
      bus(1'b1, IDX_UART_DROP, 32'hAB);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rd_chk(IDX_UART_DROP, 0);
      // Bursts with integrity errors, then selective snapshots
      for (int i = 0; i < 8; i++) begin
         burst((i < 3) ? tbl[i] : 4'($urandom), 1 + ($urandom % 40));
         all_chk();
         snap($urandom % 3);
         all_chk();
      end
      // Counting paused per port through the control register
      for (int k = 0; k < 3; k++) begin
         en = 2'(k);
         bus(1'b1, IDX_COUNT_CTRL, {30'h0, en});
         rd_chk(IDX_COUNT_CTRL, en);
         burst(4'hD, 2 + ($urandom % 9));
         snap(2);
         all_chk();
      end
      // A control write without its byte lane is ignored
      byteenable <= 4'h0;
      bus(1'b1, IDX_COUNT_CTRL, 32'h3);
      byteenable <= 4'hF;
      rd_chk(IDX_COUNT_CTRL, en);
      en = CTRL_RST;
      bus(1'b1, IDX_COUNT_CTRL, {30'h0, en});
      rd_chk(IDX_COUNT_CTRL, en);
      // Saturation of every count
      burst(4'hD, 65540);
      snap(2);
      all_chk();
      print_verdict();
   end
endmodule
`default_nettype wire
